// File: src/bml_defs.svh
// timing constants and encodings for the boot mode and status indicator block
`ifndef BML_DEFS_SVH
`define BML_DEFS_SVH
// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define BML_CLK_HZ 200000000
`define BML_SHOW_MS 3000
`define BML_SHOW_CYC ((`BML_SHOW_MS * 64'(`BML_CLK_HZ)) / 64'd1000)
`define BML_SETTLE_LAST 2'h3
`define BML_BLINKS 3
`define BML_PHASES 6
// --------------------------------------------------------------------------
// encodings
// --------------------------------------------------------------------------
`define BML_SW_UPDATE 1'h1
`define BML_PORT_RS232 1'h0
`define BML_PORT_RS485 1'h1
`endif

// File: src/bml_pkg.sv
// types shared by the boot mode and status indicator block
package bml_pkg;
    typedef enum logic [1:0] {
        BML_ST_PWRUP = 2'b00,
        BML_ST_SHOW = 2'b01,
        BML_ST_RUN = 2'b10
    } bml_state_t;
    typedef enum logic {
        BML_MODE_RUN = 1'b0,
        BML_MODE_UPDATE = 1'b1
    } bml_mode_t;
    typedef struct packed {
        logic power;
        logic learning;
        logic transmit;
    } bml_leds_t;
    typedef struct packed {
        logic mode_update;
        logic port_rs485;
    } bml_boot_t;
endpackage

// File: src/bml_sync.sv
// two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module bml_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;
    // --------------------------------------------------------------------------
    // first stage feeds only the second
    // --------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: src/bml_top.sv
// boot mode selection and status indicator driver
// Notes on behaviour
// - mode switch sampled once after reset; later changes ignored until the next reset
// - update mode grants firmware loading only to the rs-232 port
// - firmware loading never asserts writes to stored settings or learned codes
// - run mode enables parameter, learning and modbus service on serial port
// - power indicator lit while healthy, dark on fault
// - in run mode, learning indicator lit while waiting for ir, off on capture done (update mode holds it lit)
// - in run mode, transmit indicator lit while any ir channel emits
// - rs-232 port strap: three transmit blinks after power-on, off within three seconds in run mode, held lit in update mode
// - only one serial interface enabled at any time
`timescale 1ns/1ps
`default_nettype none
`include "bml_defs.svh"
module bml_top
    import bml_pkg::*;
#(
    parameter longint SHOW_CYC = `BML_SHOW_CYC,
    parameter int IR_CH = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_switch,
    input wire logic port_select,
    input wire logic fault,
    input wire logic learn_wait,
    input wire logic learn_done,
    input wire logic [IR_CH-1:0] ir_emit,
    output logic power_indicator,
    output logic learning_indicator,
    output logic transmit_indicator,
    output logic update_mode,
    output logic loader_en,
    output logic cfg_write_en,
    output logic serial_service_en,
    output logic rs232_en,
    output logic rs485_en,
    output logic boot_done
);
    localparam int PH_W = 3;
    localparam longint PHASE_CYC = SHOW_CYC / `BML_PHASES;

    // --------------------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------------------
    logic [1:0] sw_s;
    logic [2:0] st_s;
    bml_sync #(.WIDTH(2)) u_sync_sw (
        .clk(clk),
        .rst(rst),
        .din({mode_switch, port_select}),
        .dout(sw_s)
    );
    bml_sync #(.WIDTH(3)) u_sync_st (
        .clk(clk),
        .rst(rst),
        .din({fault, learn_wait, learn_done}),
        .dout(st_s)
    );

    // --------------------------------------------------------------------------
    // boot state and latched straps
    // --------------------------------------------------------------------------
    bml_state_t state_r, state_nxt;
    bml_boot_t boot_r, boot_nxt;
    logic [63:0] cnt_r, cnt_nxt;
    logic [PH_W-1:0] phase_r, phase_nxt;
    logic learn_r, learn_nxt;
    bml_leds_t leds_nxt;
    logic phase_end;
    logic show_tx;
    logic emitting;

    // strap waits three edges so the synchroniser has settled before capture
    logic [1:0] settle_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            settle_r <= 2'h0;
        end else if (settle_r != `BML_SETTLE_LAST) begin
            settle_r <= settle_r + 2'h1;
        end
    end

    assign phase_end = (cnt_r == 64'(PHASE_CYC - 1));
    assign emitting = |ir_emit;

    // state sequencing: capture, show port, then run
    always_comb begin
        state_nxt = state_r;
        boot_nxt = boot_r;
        cnt_nxt = cnt_r;
        phase_nxt = phase_r;
        case (state_r)
            BML_ST_PWRUP: begin
                if (settle_r == `BML_SETTLE_LAST) begin
                    boot_nxt.mode_update = (sw_s[1] == `BML_SW_UPDATE);
                    boot_nxt.port_rs485 = (sw_s[0] == `BML_PORT_RS485);
                    state_nxt = BML_ST_SHOW;
                    cnt_nxt = 64'h0;
                    phase_nxt = '0;
                end
            end
            BML_ST_SHOW: begin
                if (phase_end) begin
                    cnt_nxt = 64'h0;
                    if (phase_r == PH_W'(`BML_PHASES - 1)) begin
                        state_nxt = BML_ST_RUN;
                    end else begin
                        phase_nxt = phase_r + PH_W'(1);
                    end
                end else begin
                    cnt_nxt = cnt_r + 64'h1;
                end
            end
            BML_ST_RUN: begin
            end
            default: begin
                state_nxt = BML_ST_PWRUP;
            end
        endcase
    end

    // rs-232 pattern: on, off, alternating over six phases gives three blinks
    // rs-485 pattern: steady on across all phases
    assign show_tx = boot_r.port_rs485 ? 1'b1 : ~phase_r[0];

    // learning latch, capture completion wins over a new wait request
    always_comb begin
        learn_nxt = learn_r;
        if (st_s[0]) begin
            learn_nxt = 1'b0;
        end else if (st_s[1]) begin
            learn_nxt = 1'b1;
        end
    end

    // indicator values; update mode in run forces learning and transmit lit
    always_comb begin
        leds_nxt.power = ~st_s[2];
        leds_nxt.learning = learn_nxt;
        leds_nxt.transmit = emitting;
        if (state_nxt == BML_ST_SHOW) begin
            leds_nxt.transmit = show_tx;
        end else if (state_nxt == BML_ST_PWRUP) begin
            leds_nxt.transmit = 1'b0;
        end
        if (state_nxt == BML_ST_RUN && boot_nxt.mode_update) begin
            leds_nxt.learning = 1'b1;
            leds_nxt.transmit = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= BML_ST_PWRUP;
            boot_r <= '0;
            cnt_r <= 64'h0;
            phase_r <= '0;
            learn_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            boot_r <= boot_nxt;
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            learn_r <= learn_nxt;
        end
    end

    // --------------------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------------------
    logic run_nxt;
    assign run_nxt = (state_nxt == BML_ST_RUN);
    always_ff @(posedge clk) begin
        if (rst) begin
            power_indicator <= 1'b0;
            learning_indicator <= 1'b0;
            transmit_indicator <= 1'b0;
            update_mode <= 1'b0;
            loader_en <= 1'b0;
            cfg_write_en <= 1'b0;
            serial_service_en <= 1'b0;
            rs232_en <= 1'b0;
            rs485_en <= 1'b0;
            boot_done <= 1'b0;
        end else begin
            power_indicator <= leds_nxt.power;
            learning_indicator <= leds_nxt.learning;
            transmit_indicator <= leds_nxt.transmit;
            update_mode <= boot_nxt.mode_update;
            boot_done <= run_nxt;
            // loader only on rs-232 in update mode
            loader_en <= run_nxt & boot_nxt.mode_update;
            // stored settings frozen while in update mode
            cfg_write_en <= run_nxt & ~boot_nxt.mode_update;
            // full service only in run mode
            serial_service_en <= run_nxt & ~boot_nxt.mode_update;
            rs232_en <= run_nxt & (boot_nxt.mode_update | ~boot_nxt.port_rs485);
            rs485_en <= run_nxt & ~boot_nxt.mode_update & boot_nxt.port_rs485;
        end
    end

    // --------------------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------------------
    a_one_port: assert property (@(posedge clk) disable iff (rst) !(rs232_en && rs485_en))
        else $error("both serial ports enabled");
    a_strap_hold: assert property (@(posedge clk) disable iff (rst)
        (state_r == BML_ST_RUN) |=> ($stable(boot_r) && $stable(update_mode)))
        else $error("boot strap changed after capture");
    a_loader_rs232: assert property (@(posedge clk) disable iff (rst) loader_en |-> (rs232_en && update_mode))
        else $error("firmware load without rs-232 update mode");
    a_cfg_frozen: assert property (@(posedge clk) disable iff (rst) update_mode |-> !cfg_write_en)
        else $error("settings writable in update mode");
    a_run_service: assert property (@(posedge clk) disable iff (rst)
        (boot_done && !update_mode) |-> serial_service_en)
        else $error("run mode service not enabled");
    a_power_fault: assert property (@(posedge clk) disable iff (rst) st_s[2] |=> !power_indicator)
        else $error("power indicator lit during fault");
    a_learn_done: assert property (@(posedge clk) disable iff (rst)
        (st_s[0] && !update_mode && boot_done && state_nxt == BML_ST_RUN) |=> !learning_indicator)
        else $error("learning indicator stayed on after capture");
    a_tx_emit: assert property (@(posedge clk) disable iff (rst)
        (emitting && state_r == BML_ST_RUN) |=> transmit_indicator)
        else $error("transmit indicator dark while emitting");
    a_blink_232: assert property (@(posedge clk) disable iff (rst)
        (state_r == BML_ST_SHOW && state_nxt == BML_ST_SHOW && !boot_r.port_rs485 && phase_r[0])
        |=> !transmit_indicator)
        else $error("rs-232 blink off phase lit");
    a_steady_485: assert property (@(posedge clk) disable iff (rst)
        (state_r == BML_ST_SHOW && state_nxt == BML_ST_SHOW && boot_r.port_rs485) |=> transmit_indicator)
        else $error("rs-485 steady indicator dark");
    c_show_232: cover property (@(posedge clk) state_r == BML_ST_SHOW && !boot_r.port_rs485);
    c_show_485: cover property (@(posedge clk) state_r == BML_ST_SHOW && boot_r.port_rs485);
    c_update: cover property (@(posedge clk) loader_en);
    c_learn: cover property (@(posedge clk) $fell(learning_indicator));
endmodule
`default_nettype wire

// File: test/bml_far_model.sv
// far-side stand-in that drives ir channel emit levels in timed bursts
`timescale 1ns/1ps
`default_nettype none
module bml_far_model #(
    parameter int IR_CH = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [IR_CH-1:0] chans,
    input wire logic [7:0] len,
    output logic [IR_CH-1:0] ir_emit
);
    logic [7:0] left_r;
    // burst holds len+1 cycles then drops low, so a stuck indicator shows up
    always_ff @(posedge clk) begin
        if (rst || (left_r == 8'h00 && !start)) begin
            left_r <= 8'h00;
            ir_emit <= '0;
        end else if (start) begin
            left_r <= len;
            ir_emit <= chans;
        end else begin
            left_r <= left_r - 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: test/tb_boot_mode_status_led.sv
// self-checking bench for the boot mode and status indicator block
`timescale 1ns/1ps
`default_nettype none
module tb_boot_mode_status_led;
    import bml_pkg::*;
    localparam longint SHOW = 60;
    logic clk, rst, sw, port, fault, lw, ld, start;
    logic [5:0] chans, ir_emit;
    logic power_indicator, learning_indicator, transmit_indicator, update_mode;
    logic loader_en, cfg_write_en, serial_service_en, rs232_en, rs485_en, boot_done;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    bml_top #(.SHOW_CYC(SHOW), .IR_CH(6)) u_dut (.clk(clk), .rst(rst), .mode_switch(sw), .port_select(port),
        .fault(fault), .learn_wait(lw), .learn_done(ld), .ir_emit(ir_emit), .power_indicator(power_indicator),
        .learning_indicator(learning_indicator), .transmit_indicator(transmit_indicator),
        .update_mode(update_mode), .loader_en(loader_en), .cfg_write_en(cfg_write_en),
        .serial_service_en(serial_service_en), .rs232_en(rs232_en), .rs485_en(rs485_en), .boot_done(boot_done));
    bml_far_model #(.IR_CH(6)) u_far (.clk(clk), .rst(rst), .start(start), .chans(chans), .len(8'h0A),
        .ir_emit(ir_emit));
    // --------------------------------------------------------------------
    // clock, timeout and compare tasks
    // --------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // cut a hang short; whole run needs well under this
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic check_bit(string what, logic exp, logic got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_cnt(string what, int exp, int got);
        checked++;
        if (got != exp) begin
            mismatches++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // reset with given straps, then count transmit pulses of the show window
    task automatic boot(logic s, logic p, output int rises, output int on);
        logic prev;
        int i;
        @(negedge clk);
        {sw, port, rst} = {s, p, 1'b1};
        repeat (4) @(negedge clk);
        rst = 1'b0;
        {prev, rises, on} = 0;
        for (i = 0; i < 120 && boot_done !== 1'b1; i++) begin
            @(negedge clk);
            if (transmit_indicator === 1'b1 && boot_done !== 1'b1) begin
                on++;
                if (!prev) rises++;
            end
            prev = transmit_indicator;
        end
        check_bit("boot_done", 1'b1, boot_done);
        // capture lands on the fourth edge after release, then the whole show window
        check_cnt("show length", SHOW + 4, i);
    endtask
    // --------------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------------
    task automatic t_rs232_run();
        int r, n;
        boot(1'b0, 1'b0, r, n);
        check_cnt("rs232 blinks", 3, r);
        check_bit("rs232 on time", 1'b1, n <= SHOW && n > 0);
        check_bit("update_mode", 1'b0, update_mode);
        check_bit("cfg_write_en", 1'b1, cfg_write_en);
        check_bit("serial_service_en", 1'b1, serial_service_en);
        check_bit("loader_en", 1'b0, loader_en);
        check_bit("rs232_en", 1'b1, rs232_en);
        check_bit("rs485_en", 1'b0, rs485_en);
        sw = 1'b1;
        repeat (8) @(negedge clk);
        check_bit("strap ignored", 1'b0, update_mode);
        check_bit("transmit idle", 1'b0, transmit_indicator);
        {start, chans} = {1'b1, 6'h20};
        @(negedge clk);
        start = 1'b0;
        repeat (3) @(negedge clk);
        check_bit("transmit emitting", 1'b1, transmit_indicator);
        repeat (12) @(negedge clk);
        check_bit("transmit released", 1'b0, transmit_indicator);
        $display("test rs232_run done");
    endtask
    task automatic t_status();
        check_bit("power healthy", 1'b1, power_indicator);
        fault = 1'b1;
        repeat (4) @(negedge clk);
        check_bit("power fault", 1'b0, power_indicator);
        fault = 1'b0;
        lw = 1'b1;
        repeat (2) @(negedge clk);
        lw = 1'b0;
        repeat (4) @(negedge clk);
        check_bit("learn waiting", 1'b1, learning_indicator);
        ld = 1'b1;
        repeat (2) @(negedge clk);
        ld = 1'b0;
        repeat (4) @(negedge clk);
        check_bit("learn captured", 1'b0, learning_indicator);
        check_bit("power back", 1'b1, power_indicator);
        $display("test status done");
    endtask
    task automatic t_rs485_run();
        int r, n;
        boot(1'b0, 1'b1, r, n);
        check_cnt("rs485 steady", 1, r);
        check_bit("rs485 on time", 1'b1, n >= SHOW - 1 && n <= SHOW);
        check_bit("rs485_en", 1'b1, rs485_en);
        check_bit("rs232_en", 1'b0, rs232_en);
        $display("test rs485_run done");
    endtask
    task automatic t_update();
        int r, n;
        boot(1'b1, 1'b1, r, n);
        repeat (2) @(negedge clk);
        check_bit("update_mode", 1'b1, update_mode);
        check_bit("loader_en", 1'b1, loader_en);
        check_bit("rs232_en", 1'b1, rs232_en);
        check_bit("rs485_en", 1'b0, rs485_en);
        check_bit("cfg_write_en", 1'b0, cfg_write_en);
        check_bit("serial_service_en", 1'b0, serial_service_en);
        check_bit("update leds", 1'b1, transmit_indicator & learning_indicator & power_indicator);
        $display("test update done");
    endtask
    // update strap with the rs-232 port strap: blink pattern, loader on rs-232
    task automatic t_update_rs232();
        int r, n;
        boot(1'b1, 1'b0, r, n);
        check_cnt("update rs232 blinks", 3, r);
        repeat (2) @(negedge clk);
        check_bit("update loader_en", 1'b1, loader_en);
        check_bit("update rs232_en", 1'b1, rs232_en);
        check_bit("update rs485_en", 1'b0, rs485_en);
        check_bit("update cfg_write_en", 1'b0, cfg_write_en);
        $display("test update_rs232 done");
    endtask
    // main sequence
    initial begin
        {rst, sw, port, fault, lw, ld, start, chans} = {1'b1, 7'h00, 6'h00};
        t_rs232_run();
        t_status();
        t_rs485_run();
        t_update();
        t_update_rs232();
        report_and_stop();
    end
endmodule
`default_nettype wire
